/* rtc_regs.svh */
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
// register pointer values
`define REG_CTRL 4'h0
`define REG_CTRL2 4'h1
`define REG_OFFSET 4'h2
`define REG_RAM 4'h3
`define REG_SEC 4'h4
`define REG_MIN 4'h5
`define REG_HOUR 4'h6
`define REG_DAY 4'h7
`define REG_WDAY 4'h8
`define REG_MONTH 4'h9
`define REG_YEAR 4'hA
`define REG_LAST 4'hA
`define REG_FIRST 4'h0
// bus target address, upper seven bits of the address byte
`define TARGET_ADDR 7'h51
// field positions
`define CTRL_TEST 7
`define CTRL_12H 1
`define CTRL_CAP 0
`define CTRL2_MI 5
`define CTRL2_HMI 4
`define CTRL2_TF 3
`define SEC_INTEG 7
`define HOUR_PM 5
`define OFS_MODE 7
// reset values
`define RST_ZERO 8'h00
`define RST_SEC 8'h80
`define RST_DAY 8'h01
`define RST_WDAY 8'h06
`define RST_MONTH 8'h01
// bcd limits
`define BCD_59 7'h59
`define BCD_29 7'h29
`define H24_MAX 8'h23
`define H12_MAX 5'h12
`define H12_LAST 5'h11
`define H12_FIRST 5'h01
`define WDAY_MAX 8'h06
`define MONTH_MAX 8'h12
`define YEAR_MAX 8'h99
`define DAY_FIRST 8'h01
`define FEB 8'h02
// oscillator pulses per second, test divider
`define OSC_PER_SEC 16'h8000
`define TEST_DIV 16'h0004
// correction intervals in seconds: 2 hours and 4 minutes
`define CORR_SECS_M0 13'h1C20
`define CORR_SECS_M1 13'h00F0
`endif

/* rtc_pkg.sv */
package rtc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK_ADDR = 3'b010,
        ST_RX = 3'b011,
        ST_ACK_RX = 3'b100,
        ST_TX = 3'b101,
        ST_ACK_TX = 3'b110
    } i2c_state_e;
    typedef logic [7:0] bcd_t;
endpackage : rtc_pkg

/* rtc_i2c_target.sv */
`timescale 1ns/100ps
`include "rtc_regs.svh"
module rtc_i2c_target
    import rtc_pkg::*;
#(
    parameter logic [15:0] OSC_PER_SEC = `OSC_PER_SEC
)
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_osc_32k,
    output logic o_clock_out_pin,
    input wire logic i_alarm_req,
    input wire logic i_timer_req,
    input wire logic i_watchdog_req,
    output logic o_irq_out,
    output logic o_irq_oe,
    output logic o_load_cap_select
);
    // one bcd step, carry from units to tens
    function automatic bcd_t bcd_inc(input bcd_t v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                                   : {v[7:4], v[3:0] + 4'h1};
    endfunction : bcd_inc

    // month length from bcd month and bcd year
    function automatic bcd_t days_in_month(input bcd_t m, input bcd_t y);
        logic leap;
        leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                    : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
        if (m == `FEB)
            days_in_month = leap ? 8'h29 : 8'h28;
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            days_in_month = 8'h30;
        else
            days_in_month = 8'h31;
    endfunction : days_in_month

    logic [2:0] s1, s2, s3, lvl, lvl_d;
    wire [2:0] pin_in = {i_osc_32k, i_sda, i_scl};
    // three-stage synchronisers, level follows once stages two and three agree
    genvar g;
    for (g = 0; g < 3; g++)
    begin : g_sync
        always_ff @(posedge i_mclk)
        begin
            if (!i_rst_n)
            begin
                s1[g] <= 1'b1;
                s2[g] <= 1'b1;
                s3[g] <= 1'b1;
                lvl[g] <= 1'b1;
                lvl_d[g] <= 1'b1;
            end
            else
            begin
                s1[g] <= pin_in[g];
                s2[g] <= s1[g];
                s3[g] <= s2[g];
                if (s2[g] == s3[g])
                    lvl[g] <= s3[g];
                lvl_d[g] <= lvl[g];
            end
        end
    end

    // bus conditions
    wire scl = lvl[0];
    wire sda = lvl[1];
    wire scl_rise = scl & ~lvl_d[0];
    wire scl_fall = ~scl & lvl_d[0];
    wire start_det = scl & lvl_d[0] & ~sda & lvl_d[1];
    wire stop_det = scl & lvl_d[0] & sda & ~lvl_d[1];
    wire osc_rise = lvl[2] & ~lvl_d[2];

    i2c_state_e state;
    logic [3:0] bit_cnt, ptr;
    logic [7:0] shreg;
    logic rw, first_byte, busy;
    bcd_t ctrl, ctrl2, offset, ram, sec, min, hour, day, wday, month, year;
    bcd_t view [0:10];

    // transfer decode and pointer stepping
    wire byte_full = bit_cnt == 4'h8;
    wire bit_cnt_en = state == ST_ADDR || state == ST_RX || state == ST_TX;
    wire addr_match = shreg[7:1] == `TARGET_ADDR;
    wire rx_done = state == ST_RX && scl_fall && byte_full;
    wire wr_en = rx_done && !first_byte;
    wire [3:0] next_ptr = (ptr >= `REG_LAST) ? `REG_FIRST : ptr + 4'h1;
    assign view = '{ctrl, ctrl2, offset, ram, sec, min, hour, day, wday,
                    month, year};
    wire bcd_t rd_data = (ptr <= `REG_LAST) ? view[ptr] : 8'h00;

    // bus target state machine
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            rw <= 1'b0;
            first_byte <= 1'b0;
            ptr <= `REG_FIRST;
            busy <= 1'b0;
        end
        else if (start_det)
        begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            busy <= 1'b1;
        end
        else if (stop_det)
        begin
            state <= ST_IDLE;
            busy <= 1'b0;
        end
        else
        begin
            if (scl_rise && bit_cnt_en)
                bit_cnt <= bit_cnt + 4'h1;
            unique case (state)
                ST_IDLE:
                    bit_cnt <= 4'h0;
                ST_ADDR:
                    if (scl_rise)
                        shreg <= {shreg[6:0], sda};
                    else if (scl_fall && byte_full)
                    begin
                        bit_cnt <= 4'h0;
                        rw <= shreg[0];
                        state <= addr_match ? ST_ACK_ADDR : ST_IDLE;
                    end
                ST_ACK_ADDR:
                    if (scl_fall)
                    begin
                        state <= rw ? ST_TX : ST_RX;
                        first_byte <= ~rw;
                        shreg <= rd_data;
                    end
                ST_RX:
                    if (scl_rise)
                        shreg <= {shreg[6:0], sda};
                    else if (rx_done)
                    begin
                        bit_cnt <= 4'h0;
                        state <= ST_ACK_RX;
                        ptr <= first_byte ? shreg[3:0] : next_ptr;
                    end
                ST_ACK_RX:
                    if (scl_fall)
                    begin
                        state <= ST_RX;
                        first_byte <= 1'b0;
                    end
                ST_TX:
                    if (scl_fall && byte_full)
                    begin
                        bit_cnt <= 4'h0;
                        state <= ST_ACK_TX;
                        ptr <= next_ptr;
                    end
                    else if (scl_fall)
                        shreg <= {shreg[6:0], 1'b0};
                ST_ACK_TX:
                    if (scl_rise && sda)
                        state <= ST_IDLE;
                    else if (scl_fall)
                    begin
                        state <= ST_TX;
                        shreg <= rd_data;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // open-drain data line: ack slots and zero data bits pull low
    assign o_sda_out = 1'b0;
    assign o_sda_oe = state == ST_ACK_ADDR || state == ST_ACK_RX
                      || (state == ST_TX && !shreg[7]);

    // second prescaler with periodic correction
    logic [15:0] osc_cnt;
    logic [12:0] corr_cnt;
    logic tick_pending;
    wire test_mode = ctrl[`CTRL_TEST];
    wire [12:0] corr_len = offset[`OFS_MODE] ? `CORR_SECS_M1
                                              : `CORR_SECS_M0;
    // compare as a bound so a switch to the short interval cannot skip it
    wire corr_sec = corr_cnt >= corr_len - 13'h0001;
    wire [15:0] ofs_ext = {{9{offset[6]}}, offset[6:0]};
    wire [15:0] sec_len = test_mode ? `TEST_DIV
                        : corr_sec ? OSC_PER_SEC - ofs_ext : OSC_PER_SEC;
    wire sec_due = osc_rise && osc_cnt >= sec_len - 16'h0001;
    wire tick_apply = tick_pending && !busy;
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            osc_cnt <= 16'h0000;
            corr_cnt <= 13'h0000;
            tick_pending <= 1'b0;
            o_clock_out_pin <= 1'b0;
        end
        else
        begin
            if (sec_due)
                osc_cnt <= 16'h0000;
            else if (osc_rise)
                osc_cnt <= osc_cnt + 16'h0001;
            if (sec_due)
                corr_cnt <= corr_sec ? 13'h0000 : corr_cnt + 13'h0001;
            // one pending second held, so accesses stay under a second
            tick_pending <= sec_due | (tick_pending & ~tick_apply);
            o_clock_out_pin <= lvl[2];
        end
    end

    // calendar carry chain
    wire h12 = ctrl[`CTRL_12H];
    wire pm = hour[`HOUR_PM];
    wire [4:0] h_bcd = hour[4:0];
    wire bcd_t hour_inc = bcd_inc(hour);
    wire sec_wrap = sec[6:0] == `BCD_59;
    wire min_wrap = min[6:0] == `BCD_59;
    wire hour_wrap = h12 ? (pm && h_bcd == `H12_LAST) : hour == `H24_MAX;
    wire day_wrap = day == days_in_month(month, year);
    wire month_wrap = month == `MONTH_MAX;
    wire min_step = sec_wrap;
    wire hour_step = min_step && min_wrap;
    wire day_step = hour_step && hour_wrap;
    wire month_step = day_step && day_wrap;
    wire year_step = month_step && month_wrap;
    wire bcd_t next_sec = sec_wrap ? {sec[`SEC_INTEG], 7'h00} : bcd_inc(sec);
    wire bcd_t next_min = min_wrap ? 8'h00 : bcd_inc(min);
    wire bcd_t next_hour12 = (h_bcd == `H12_MAX) ? {2'b00, pm, `H12_FIRST}
                           : (h_bcd == `H12_LAST) ? {2'b00, ~pm, `H12_MAX}
                           : {2'b00, pm, hour_inc[4:0]};
    wire bcd_t next_hour24 = hour_wrap ? 8'h00 : hour_inc;
    wire bcd_t next_day = day_wrap ? `DAY_FIRST : bcd_inc(day);
    wire bcd_t next_wday = (wday >= `WDAY_MAX) ? 8'h00 : wday + 8'h01;
    wire bcd_t next_month = month_wrap ? `DAY_FIRST : bcd_inc(month);
    wire bcd_t next_year = (year == `YEAR_MAX) ? 8'h00 : bcd_inc(year);

    // time and control registers: host writes, otherwise applied ticks
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            ctrl <= `RST_ZERO;
            offset <= `RST_ZERO;
            ram <= `RST_ZERO;
            sec <= `RST_SEC;
            min <= `RST_ZERO;
            hour <= `RST_ZERO;
            day <= `RST_DAY;
            wday <= `RST_WDAY;
            month <= `RST_MONTH;
            year <= `RST_ZERO;
        end
        else if (wr_en)
        begin
            if (ptr == `REG_CTRL)
                ctrl <= shreg;
            if (ptr == `REG_OFFSET)
                offset <= shreg;
            if (ptr == `REG_RAM)
                ram <= shreg;
            if (ptr == `REG_SEC)
                sec <= shreg;
            if (ptr == `REG_MIN)
                min <= shreg;
            if (ptr == `REG_HOUR)
                hour <= shreg;
            if (ptr == `REG_DAY)
                day <= shreg;
            if (ptr == `REG_WDAY)
                wday <= shreg;
            if (ptr == `REG_MONTH)
                month <= shreg;
            if (ptr == `REG_YEAR)
                year <= shreg;
        end
        else if (tick_apply)
        begin
            sec <= next_sec;
            if (min_step)
                min <= next_min;
            if (hour_step)
                hour <= h12 ? next_hour12 : next_hour24;
            if (day_step)
                day <= next_day;
            if (day_step)
                wday <= next_wday;
            if (month_step)
                month <= next_month;
            if (year_step)
                year <= next_year;
        end
    end

    // periodic flag: set wins over a clearing write of zero
    wire wr_ctrl2 = wr_en && ptr == `REG_CTRL2;
    wire per_event = tick_apply && ((ctrl2[`CTRL2_MI] && sec_wrap)
        || (ctrl2[`CTRL2_HMI] && (sec_wrap || sec[6:0] == `BCD_29)));
    wire flag_keep = ctrl2[`CTRL2_TF] && !(wr_ctrl2 && !shreg[`CTRL2_TF]);
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            ctrl2 <= `RST_ZERO;
        else
        begin
            if (wr_ctrl2)
                ctrl2 <= shreg;
            ctrl2[`CTRL2_TF] <= per_event | flag_keep;
        end
    end

    // open-drain interrupt, low while any source is active
    assign o_irq_out = 1'b0;
    assign o_irq_oe = ctrl2[`CTRL2_TF] | i_alarm_req | i_timer_req
                      | i_watchdog_req;
    assign o_load_cap_select = ctrl[`CTRL_CAP];

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    sequence s_tick_at_59;
        tick_apply && sec_wrap;
    endsequence
    property p_freeze;
        busy && !wr_en |=> $stable(sec);
    endproperty
    a_freeze: assert property (p_freeze) else $error("time moved in access");
    property p_pending;
        tick_pending && !busy |=> !tick_pending || $past(sec_due);
    endproperty
    a_pending: assert property (p_pending) else $error("tick not applied");
    property p_wrap;
        s_tick_at_59 |=> sec[6:0] == 7'h00 && $changed(min);
    endproperty
    a_wrap: assert property (p_wrap) else $error("minute carry lost");
    property p_leap;
        tick_apply && day_step && month == `FEB && day == 8'h28
            && year == 8'h24 |=> day == 8'h29;
    endproperty
    a_leap: assert property (p_leap) else $error("leap day skipped");
    property p_minute_irq;
        s_tick_at_59 and ctrl2[`CTRL2_MI] |=> ctrl2[`CTRL2_TF] && o_irq_oe;
    endproperty
    a_minute_irq: assert property (p_minute_irq) else $error("no irq");
    property p_sources;
        i_alarm_req || i_timer_req || i_watchdog_req |-> o_irq_oe;
    endproperty
    a_sources: assert property (p_sources) else $error("irq not driven");
    property p_ram;
        wr_en && ptr == `REG_RAM |=> ram == $past(shreg);
    endproperty
    a_ram: assert property (p_ram) else $error("scratch write lost");
    property p_test;
        sec_due && test_mode |-> osc_cnt == `TEST_DIV - 16'h0001;
    endproperty
    a_test: assert property (p_test) else $error("test divider wrong");
    property p_addr;
        state == ST_ADDR && scl_fall && byte_full && addr_match && !start_det
            && !stop_det |=> state == ST_ACK_ADDR ##0 o_sda_oe;
    endproperty
    a_addr: assert property (p_addr) else $error("address not acked");
    property p_ptr;
        rx_done && first_byte && !start_det && !stop_det
            |=> ptr == $past(shreg[3:0]);
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer not loaded");
endmodule : rtc_i2c_target

/* i2c_host_model.sv */
`timescale 1ns/100ps
// bus host: clock driven by the host, data open drain with pull-up
module i2c_host_model
(
    input wire logic i_mclk,
    input wire logic i_dev_oe,
    output logic o_scl,
    output logic o_sda
);
    logic pull = 1'b0;
    initial o_scl = 1'b1;
    // wire level: high unless some party pulls it low
    assign o_sda = ~(pull | i_dev_oe);
    // change pins after the edge, then hold them n cycles
    task automatic ph(input logic c, input logic p, input int n);
        o_scl <= c;
        pull <= p;
        repeat (n) @(posedge i_mclk);
    endtask : ph
    // start or repeated start: data falls while clock is high
    task automatic start;
        ph(1'b0, pull, 8);
        ph(1'b0, 1'b0, 8);
        ph(1'b1, 1'b0, 16);
        ph(1'b1, 1'b1, 16);
        ph(1'b0, 1'b1, 16);
    endtask : start
    // stop: data rises while clock is high
    task automatic stop;
        ph(1'b0, pull, 8);
        ph(1'b0, 1'b1, 8);
        ph(1'b1, 1'b1, 16);
        ph(1'b1, 1'b0, 16);
    endtask : stop
    // eight bits msb first plus ninth bit; data moves only while low
    task automatic xfer(input logic [7:0] d, input logic b9,
                        output logic [7:0] q, output logic ack);
        logic [8:0] w;
        w = {d, b9};
        for (int i = 8; i >= 0; i--)
        begin
            ph(1'b0, pull, 8);
            ph(1'b0, ~w[i], 8);
            ph(1'b1, ~w[i], 16);
            if (i > 0)
                q[i-1] = o_sda;
            else
                ack = ~o_sda;
        end
    endtask : xfer
endmodule : i2c_host_model

/* rtc_i2c_target_tb_top.sv */
`timescale 1ns/100ps
// bench: register access over the bus, calendar, interrupt, clock out
module rtc_i2c_target_tb_top
    import rtc_pkg::*;
;
    typedef bcd_t bytes_t[$];
    localparam int SEC = 8; // oscillator edges per second, shortened
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic osc = 1'b0;
    logic [2:0] req = 3'h0;
    logic scl, sda, sda_oe, clk_out, irq_oe, load_cap_select, sda_out, irq_out;
    logic [7:0] q;
    logic a;
    bytes_t e;
    int error_cnt = 0;
    int checked = 0;
    always #5 mclk = ~mclk;
    rtc_i2c_target #(.OSC_PER_SEC(16'(SEC))) rtc_i2c_target_inst
    (
        .i_mclk(mclk),
        .i_rst_n(rst_n),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_out(sda_out),
        .o_sda_oe(sda_oe),
        .i_osc_32k(osc),
        .o_clock_out_pin(clk_out),
        .i_alarm_req(req[0]),
        .i_timer_req(req[1]),
        .i_watchdog_req(req[2]),
        .o_irq_out(irq_out),
        .o_irq_oe(irq_oe),
        .o_load_cap_select(load_cap_select)
    );
    i2c_host_model i2c_host_model_inst
    (
        .i_mclk(mclk),
        .i_dev_oe(sda_oe),
        .o_scl(scl),
        .o_sda(sda)
    );
    // verdict and end of run
    task automatic end_sim;
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // byte compare
    task automatic cmp8(input bcd_t got, input bcd_t exp);
        checked++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : cmp8
    // flag compare
    task automatic cmp1(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : cmp1
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    // oscillator edges; clock out must follow each level
    task automatic run(input int n);
        repeat (n)
        begin
            osc <= 1'b1;
            cyc(8);
            cmp1(clk_out, 1'b1);
            osc <= 1'b0;
            cyc(8);
            cmp1(clk_out, 1'b0);
        end
    endtask : run
    // write burst: address, pointer, then data bytes
    task automatic reg_wr(input bcd_t p, input bytes_t d);
        logic [7:0] r;
        logic k;
        i2c_host_model_inst.start();
        i2c_host_model_inst.xfer(8'hA2, 1'b1, r, k);
        cmp1(k, 1'b1);
        i2c_host_model_inst.xfer(p, 1'b1, r, k);
        cmp1(k, 1'b1);
        foreach (d[i])
            i2c_host_model_inst.xfer(d[i], 1'b1, r, k);
        i2c_host_model_inst.stop();
    endtask : reg_wr
    // read burst; mid oscillator edges pass before the data phase
    task automatic reg_rd(input bcd_t p, input bytes_t x, input int mid);
        logic [7:0] r;
        logic k;
        i2c_host_model_inst.start();
        i2c_host_model_inst.xfer(8'hA2, 1'b1, r, k);
        i2c_host_model_inst.xfer(p, 1'b1, r, k);
        i2c_host_model_inst.start();
        i2c_host_model_inst.xfer(8'hA3, 1'b1, r, k);
        cmp1(k, 1'b1);
        run(mid);
        foreach (x[i])
        begin
            i2c_host_model_inst.xfer(8'hFF, i == x.size() - 1, r, k);
            cmp8(r, x[i]);
        end
        i2c_host_model_inst.stop();
    endtask : reg_rd
    // hang guard
    initial
    begin
        #900000;
        error_cnt++;
        end_sim();
    end
    // main sequence
    initial
    begin
        cyc(10);
        rst_n <= 1'b1;
        cyc(6);
        cmp1(load_cap_select, 1'b0);
        cmp1(irq_oe, 1'b0);
        cmp1(sda_out, 1'b0);
        cmp1(irq_out, 1'b0);
        e = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00, 8'h01,
              8'h06, 8'h01, 8'h00};
        reg_rd(8'h00, e, 0);
        i2c_host_model_inst.start();
        i2c_host_model_inst.xfer(8'hA4, 1'b1, q, a);
        cmp1(a, 1'b0);
        i2c_host_model_inst.stop();
        // scratch byte, offset, unmapped pointer
        reg_wr(8'h02, '{8'h85, 8'hA5});
        reg_wr(8'h0B, '{8'h55});
        reg_rd(8'h02, '{8'h85, 8'hA5}, 0);
        reg_rd(8'h0B, '{8'h00}, 0);
        reg_wr(8'h02, '{8'h00});
        reg_wr(8'h00, '{8'h01});
        cmp1(load_cap_select, 1'b1);
        reg_wr(8'h00, '{8'h02});
        cmp1(load_cap_select, 1'b0);
        // 12 h mode, 11:59:59 pm on 28 feb of a leap year
        reg_wr(8'h04, '{8'h59, 8'h59, 8'h31, 8'h28, 8'h05, 8'h02,
                        8'h24});
        run(SEC);
        e = '{8'h00, 8'h00, 8'h12, 8'h29, 8'h06, 8'h02, 8'h24};
        reg_rd(8'h04, e, 0);
        // 24 h mode, 28 feb of a common year, weekday wraps
        reg_wr(8'h00, '{8'h00});
        reg_wr(8'h04, '{8'h59, 8'h59, 8'h23, 8'h28, 8'h06, 8'h02,
                        8'h23});
        run(SEC);
        e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h23};
        reg_rd(8'h04, e, 0);
        // end of year 99
        reg_wr(8'h04, '{8'h59, 8'h59, 8'h23, 8'h31, 8'h06, 8'h12,
                        8'h99});
        run(SEC);
        e = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
        reg_rd(8'h04, e, 0);
        // second falls due inside a read, applied after stop
        run(SEC - 1);
        reg_rd(8'h04, '{8'h00}, 1);
        reg_rd(8'h04, '{8'h01}, 0);
        // test speed-up: four edges make a second
        reg_wr(8'h00, '{8'h80});
        run(4);
        reg_rd(8'h04, '{8'h02}, 0);
        reg_wr(8'h00, '{8'h00});
        // half-minute and minute periodic flag
        reg_wr(8'h01, '{8'h10});
        reg_wr(8'h04, '{8'h29});
        run(SEC);
        cmp1(irq_oe, 1'b1);
        reg_wr(8'h01, '{8'h20});
        cmp1(irq_oe, 1'b0);
        reg_wr(8'h04, '{8'h29});
        run(SEC);
        cmp1(irq_oe, 1'b0);
        reg_wr(8'h04, '{8'h59});
        run(SEC);
        cmp1(irq_oe, 1'b1);
        reg_wr(8'h01, '{8'h00});
        cmp1(irq_oe, 1'b0);
        // alarm, timer and watchdog each drive the interrupt pin
        for (int k = 0; k < 3; k++)
        begin
            req <= 3'h1 << k;
            cyc(2);
            cmp1(irq_oe, 1'b1);
            cmp1(irq_out, 1'b0);
            req <= 3'h0;
            cyc(2);
            cmp1(irq_oe, 1'b0);
        end
        reg_rd(8'h09, '{8'h01, 8'h00, 8'h00}, 0);
        end_sim();
    end
endmodule : rtc_i2c_target_tb_top
